/* channel_status_upper_bytes_codec_bench.sv */
// Self-checking bench for the channel status codec with a loopback link.
`timescale 1ns/1ns
module channel_status_upper_bytes_codec_bench;
    import csu_pkg::*;
    logic         ref_clk, sys_rst, ce, wr, rd, irq, tx_frame, tx_bit, tx_bos, run;
    logic         rx_frame, rx_bit, rx_bos, mc, mrsv, scale, crc_ok;
    logic [7:0]   addr, chan, flip, nblk;
    logic [31:0]  wdata, rdata, rv, seed;
    logic [2:0]   mode, gap;
    logic [1:0]   refg;
    logic [3:0]   rate, rel;
    logic [191:0] blk;
    logic [7:0]   by [0:23];
    logic [31:0]  txv [0:5];
    logic [3:0]   rtab [0:9] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hb, 4'hf, 4'h0, 4'h5, 4'hc};
    int           n_mismatch, comparisons, cyc;

    csu_codec uut (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .tx_frame_i(tx_frame), .tx_bit_o(tx_bit),
        .tx_bos_o(tx_bos), .rx_frame_i(rx_frame), .rx_bit_i(rx_bit), .rx_bos_i(rx_bos), .rx_chan_o(chan),
        .rx_mc_o(mc), .rx_mode_o(mode), .rx_mode_rsvd_o(mrsv), .rx_ref_o(refg), .rx_rate_o(rate),
        .rx_scale_o(scale), .rx_rel_o(rel), .rx_crc_ok_o(crc_ok));
    csu_link_model link (.clk_i(ref_clk), .rst_i(sys_rst), .run_i(run), .gap_i(gap), .flip_i(flip),
        .tx_bit_i(tx_bit), .tx_bos_i(tx_bos), .tx_frame_o(tx_frame), .rx_frame_o(rx_frame),
        .rx_bit_o(rx_bit), .rx_bos_o(rx_bos), .blk_o(blk), .nblk_o(nblk));

    always #20 ref_clk = ~ref_clk;

    // Ten blocks of at most 1400 cycles each fit well inside this ceiling.
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic results();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        logic [31:0] v;
        v = s;
        for (int k = 0; k < 32; k++) v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
        return v;
    endfunction

    function automatic logic [7:0] crc8();
        logic [7:0] c;
        c = 8'hff;
        for (int k = 0; k < 184; k++) c = (c >> 1) ^ ((c[0] ^ by[k/8][k%8]) ? 8'hb8 : 8'h00);
        return c;
    endfunction

    task automatic wrt(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rdr(input logic [7:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 rv = rdata;
        @(posedge ref_clk);
    endtask

    task automatic scen(input int i);
        logic [7:0] b3, b4, st, n0;
        logic       ok, rsv;
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            txv[k] = seed;
        end
        b3 = (i < 8) ? {1'b1, i[2:0], txv[1][3:0]} : {1'b0, txv[1][6:0]};
        b4 = {txv[1][15], rtab[i], txv[1][10], i[1:0]};
        txv[1] = {12'h000, txv[1][19:16], b4, b3};
        txv[0] = {8'h00, txv[0][23:0]};
        for (int k = 0; k < 6; k++) wrt(A_TX_HDR + 8'(4 * k), txv[k]);
        for (int k = 0; k < 24; k++) by[k] = (k < 3) ? txv[0][8*k +: 8] : 8'h00;
        for (int k = 6; k < 22; k++) by[k] = txv[(k - 6) / 4 + 2][8 * ((k - 6) % 4) +: 8];
        by[3] = b3;
        by[4] = {b4[7:3], 1'b0, (b4[1:0] == 2'b11) ? 2'b00 : b4[1:0]};
        by[22] = {txv[1][19:16], 4'h0};
        by[23] = crc8();
        ok = (i != 9);
        // The damaged block flips byte 4 bit 1, so its grade one pattern arrives as the reserved 11.
        rsv = (b3[7] && (b3[6:4] inside {3'h4, 3'h5, 3'h6})) || !ok;
        gap <= (i % 2) ? 3'h3 : 3'h0;
        flip <= ok ? 8'hff : 8'h21;
        n0 = nblk;
        run <= 1'b1;
        for (int w = 0; w < 3000 && nblk == n0; w++) @(posedge ref_clk);
        run <= 1'b0;
        repeat (4) @(posedge ref_clk);
        for (int k = 0; k < 24; k++) chk("tx byte", 32'(blk[8*k +: 8]), 32'(by[k]));
        chk("byte5", 32'(blk[47:40]), 32'h0);
        chk("byte22 low", 32'(blk[179:176]), 32'h0);
        chk("check byte", 32'(blk[191:184]), 32'(by[23]));
        chk("ref sent", 32'(blk[33:32]), 32'(by[4][1:0]));
        chk("crc ok", 32'(crc_ok), 32'(ok));
        chk("reliability", 32'(rel), ok ? 32'(by[22][7:4]) : 32'h0);
        if (ok) begin
            if (b3[7]) chk("channel", 32'(chan), 32'(b3[3:0]) + 1);
            else chk("channel", 32'(chan), 32'(b3[6:0]) + 1);
            chk("mc", 32'(mc), 32'(b3[7]));
            chk("mode", 32'(mode), 32'(b3[6:4]));
            chk("mode reserved", 32'(mrsv), 32'(rsv));
            chk("ref", 32'(refg), 32'(by[4][1:0]));
            chk("rate", 32'(rate), 32'(b4[6:3]));
            chk("scale", 32'(scale), 32'(b4[7]));
            rdr(A_RX_ORG);
            chk("origin", rv, txv[2]);
            rdr(A_RX_DST);
            chk("destination", rv, txv[3]);
            rdr(A_RX_LSA);
            chk("local address", rv, txv[4]);
            rdr(A_RX_TOD);
            chk("time of day", rv, txv[5]);
        end
        rdr(A_IRQ_ST);
        st = {4'h0, rsv, 1'b1, !ok, 1'b1};
        chk("irq status", rv, 32'(st));
        chk("irq level", 32'(irq), 32'(|(st[3:0] & 4'ha)));
        wrt(A_IRQ_ST, 32'h0000000f);
        chk("irq cleared", 32'(irq), 32'h0);
        $display("block %0d done", i);
    endtask

    initial begin
        ref_clk = 1'b0;
        sys_rst = 1'b1;
        ce = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        run = 1'b0;
        gap = 3'h0;
        flip = 8'hff;
        seed = 32'h23;
        n_mismatch = 0;
        comparisons = 0;
        cyc = 0;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rdr(A_TX_HDR);
        chk("tx_hdr reset", rv, {8'h00, TX_HDR_RST});
        #1 chk("rdata after read", rdata, 32'h0);
        @(posedge ref_clk);
        // A write while the clock enable is low must leave the mask untouched.
        ce <= 1'b0;
        wrt(A_IRQ_MSK, 32'h0000000f);
        ce <= 1'b1;
        rdr(A_IRQ_MSK);
        chk("irq_msk reset", rv, 32'h0);
        rdr(8'h3c);
        chk("unmapped read", rv, 32'h0);
        wrt(A_IRQ_MSK, 32'h0000000a);
        $display("reset test done");
        for (int i = 0; i < 10; i++) scen(i);
        results();
    end
endmodule

/* csu_codec.sv */
// Channel status formatter and interpreter for bytes 3 to 23 of the block.
`timescale 1ns/1ns
module csu_codec
    import csu_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    output logic             irq_o,
    input  wire logic        tx_frame_i,
    output logic             tx_bit_o,
    output logic             tx_bos_o,
    input  wire logic        rx_frame_i,
    input  wire logic        rx_bit_i,
    input  wire logic        rx_bos_i,
    output logic      [7:0]  rx_chan_o,
    output logic             rx_mc_o,
    output logic      [2:0]  rx_mode_o,
    output logic             rx_mode_rsvd_o,
    output logic      [1:0]  rx_ref_o,
    output logic      [3:0]  rx_rate_o,
    output logic             rx_scale_o,
    output logic      [3:0]  rx_rel_o,
    output logic             rx_crc_ok_o
);
    import csu_pkg::*;

    // One serial step of the reflected CRC; the generator is x^8+x^4+x^3+x^2+1.
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
        crc_step = (c[0] ^ b) ? ((c >> 1) ^ CRC_POLY_R) : (c >> 1);
    endfunction

    function automatic logic [7:0] chan_dec(input logic [7:0] b3);
        if (b3[7])
            chan_dec = {4'h0, b3[3:0]} + 8'h01;
        else
            chan_dec = {1'b0, b3[6:0]} + 8'h01;
    endfunction

    function automatic logic mode_rsvd(input logic [2:0] m);
        case (m)
            MODE_0, MODE_2, MODE_3, MODE_4, MODE_USER: mode_rsvd = 1'b0;
            default: mode_rsvd = 1'b1;
        endcase
    endfunction

    logic [23:0]  tx_hdr_ff;
    logic [19:0]  tx_fmt_ff;
    logic [31:0]  tx_org_ff;
    logic [31:0]  tx_dst_ff;
    logic [31:0]  tx_lsa_ff;
    logic [31:0]  tx_tod_ff;
    logic [183:0] tx_live;
    logic [183:0] tx_blk_ff;
    logic [183:0] tx_src;
    logic [7:0]   tx_idx_ff;
    logic [7:0]   tx_crc_ff;
    logic [7:0]   tx_crc_in;
    logic         tx_data_bit;
    logic [7:0]   rx_idx_ff;
    logic [7:0]   rx_idx;
    logic [7:0]   rx_crc_ff;
    logic [7:0]   nxt_rx_crc;
    logic [191:0] rx_sr_ff;
    logic [191:0] rx_blk;
    logic         rx_done;
    logic [23:0]  rx_hdr_ff;
    logic [7:0]   rx_b3_ff;
    logic [7:0]   rx_b4_ff;
    logic [31:0]  rx_org_ff;
    logic [31:0]  rx_dst_ff;
    logic [31:0]  rx_lsa_ff;
    logic [31:0]  rx_tod_ff;
    logic [3:0]   rx_rel_ff;
    logic         rx_crc_ok_ff;
    logic [3:0]   irq_st_ff;
    logic [3:0]   irq_msk_ff;
    logic [3:0]   irq_set;
    logic [3:0]   irq_clr;

    // Byte 5 and the low nibble of byte 22 are hard zeros, and the reserved
    // reference pattern is sent as "not a reference" rather than passed on.
    always_comb begin
        tx_live = {tx_fmt_ff[19:16], 4'h0,
                   tx_tod_ff, tx_lsa_ff, tx_dst_ff, tx_org_ff,
                   8'h00,
                   tx_fmt_ff[15:11], 1'b0,
                   (tx_fmt_ff[9:8] == REF_RSV) ? 2'b00 : tx_fmt_ff[9:8],
                   tx_fmt_ff[7:0], tx_hdr_ff};
    end

    // The whole block is frozen at its first bit so that a register write in
    // mid-block cannot tear the fields or the check byte.
    assign tx_src      = (tx_idx_ff == 8'h00) ? tx_live : tx_blk_ff;
    assign tx_data_bit = tx_src[tx_idx_ff];
    assign tx_crc_in   = (tx_idx_ff == 8'h00) ? CRC_INIT : tx_crc_ff;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_idx_ff <= 8'h00;
            tx_crc_ff <= CRC_INIT;
            tx_blk_ff <= '0;
            tx_bit_o  <= 1'b0;
            tx_bos_o  <= 1'b0;
        end else if (ce_i && tx_frame_i) begin
            tx_bos_o  <= (tx_idx_ff == 8'h00);
            tx_idx_ff <= (tx_idx_ff == BLK_LAST) ? 8'h00 : tx_idx_ff + 8'h01;
            if (tx_idx_ff == 8'h00)
                tx_blk_ff <= tx_live;
            if (tx_idx_ff < CRC_FIRST) begin
                tx_bit_o  <= tx_data_bit;
                tx_crc_ff <= crc_step(tx_crc_in, tx_data_bit);
            end else begin
                tx_bit_o  <= tx_crc_ff[0];
                tx_crc_ff <= {1'b0, tx_crc_ff[7:1]};
            end
        end
    end

    // A block start marker from the receiver realigns the bit count at once.
    assign rx_idx     = rx_bos_i ? 8'h00 : rx_idx_ff;
    assign nxt_rx_crc = crc_step(rx_bos_i ? CRC_INIT : rx_crc_ff, rx_bit_i);
    assign rx_blk     = {rx_bit_i, rx_sr_ff[191:1]};
    assign rx_done    = ce_i && rx_frame_i && (rx_idx == BLK_LAST);

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_idx_ff <= 8'h00;
            rx_crc_ff <= CRC_INIT;
            rx_sr_ff  <= '0;
        end else if (ce_i && rx_frame_i) begin
            rx_sr_ff  <= rx_blk;
            rx_idx_ff <= (rx_idx == BLK_LAST) ? 8'h00 : rx_idx + 8'h01;
            rx_crc_ff <= (rx_idx == BLK_LAST) ? CRC_INIT : nxt_rx_crc;
        end
    end

    // Running the check over all 192 bits leaves zero when byte 23 matches.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_hdr_ff    <= '0;
            rx_b3_ff     <= 8'h00;
            rx_b4_ff     <= 8'h00;
            rx_org_ff    <= '0;
            rx_dst_ff    <= '0;
            rx_lsa_ff    <= '0;
            rx_tod_ff    <= '0;
            rx_rel_ff    <= 4'h0;
            rx_crc_ok_ff <= 1'b0;
        end else if (rx_done) begin
            rx_hdr_ff    <= rx_blk[23:0];
            rx_b3_ff     <= rx_blk[31:24];
            rx_b4_ff     <= rx_blk[39:32];
            rx_org_ff    <= rx_blk[79:48];
            rx_dst_ff    <= rx_blk[111:80];
            rx_lsa_ff    <= rx_blk[143:112];
            rx_tod_ff    <= rx_blk[175:144];
            rx_crc_ok_ff <= (nxt_rx_crc == 8'h00);
            rx_rel_ff    <= (nxt_rx_crc == 8'h00) ? rx_blk[183:180] : 4'h0;
        end
    end

    assign rx_chan_o      = chan_dec(rx_b3_ff);
    assign rx_mc_o        = rx_b3_ff[7];
    assign rx_mode_o      = rx_b3_ff[6:4];
    assign rx_mode_rsvd_o = rx_b3_ff[7] && mode_rsvd(rx_b3_ff[6:4]);
    assign rx_ref_o       = rx_b4_ff[1:0];
    assign rx_rate_o      = rx_b4_ff[6:3];
    assign rx_scale_o     = rx_b4_ff[7];
    assign rx_rel_o       = rx_rel_ff;
    assign rx_crc_ok_o    = rx_crc_ok_ff;

    always_comb begin
        irq_set = 4'h0;
        irq_set[IRQ_RX_DONE] = rx_done;
        irq_set[IRQ_CRC_ERR] = rx_done && (nxt_rx_crc != 8'h00);
        irq_set[IRQ_TX_BLK]  = ce_i && tx_frame_i && (tx_idx_ff == 8'h00);
        irq_set[IRQ_RX_RSV]  = rx_done && ((rx_blk[33:32] == REF_RSV) ||
                               (rx_blk[31] && mode_rsvd(rx_blk[30:28])));
        irq_clr = (wr_i && addr_i == A_IRQ_ST) ? wdata_i[3:0] : 4'h0;
    end

    // A new event in the clearing cycle survives the write-one-to-clear.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            irq_st_ff <= 4'h0;
        else if (ce_i)
            irq_st_ff <= (irq_st_ff & ~irq_clr) | irq_set;
    end

    assign irq_o = |(irq_st_ff & irq_msk_ff);

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_hdr_ff  <= TX_HDR_RST;
            tx_fmt_ff  <= TX_FMT_RST;
            tx_org_ff  <= '0;
            tx_dst_ff  <= '0;
            tx_lsa_ff  <= '0;
            tx_tod_ff  <= '0;
            irq_msk_ff <= IRQ_MSK_RST;
        end else if (ce_i && wr_i) begin
            case (addr_i)
                A_TX_HDR: tx_hdr_ff  <= wdata_i[23:0];
                A_TX_FMT: tx_fmt_ff  <= wdata_i[19:0];
                A_TX_ORG: tx_org_ff  <= wdata_i;
                A_TX_DST: tx_dst_ff  <= wdata_i;
                A_TX_LSA: tx_lsa_ff  <= wdata_i;
                A_TX_TOD: tx_tod_ff  <= wdata_i;
                A_IRQ_MSK: irq_msk_ff <= wdata_i[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_o <= '0;
        end else if (ce_i) begin
            rdata_o <= '0;
            if (rd_i) begin
                case (addr_i)
                    A_TX_HDR: rdata_o <= {8'h00, tx_hdr_ff};
                    A_TX_FMT: rdata_o <= {12'h000, tx_fmt_ff};
                    A_TX_ORG: rdata_o <= tx_org_ff;
                    A_TX_DST: rdata_o <= tx_dst_ff;
                    A_TX_LSA: rdata_o <= tx_lsa_ff;
                    A_TX_TOD: rdata_o <= tx_tod_ff;
                    A_RX_HDR: rdata_o <= {8'h00, rx_hdr_ff};
                    A_RX_FMT: rdata_o <= {rx_chan_o, 3'h0, rx_crc_ok_ff, rx_rel_ff, rx_b4_ff, rx_b3_ff};
                    A_RX_ORG: rdata_o <= rx_org_ff;
                    A_RX_DST: rdata_o <= rx_dst_ff;
                    A_RX_LSA: rdata_o <= rx_lsa_ff;
                    A_RX_TOD: rdata_o <= rx_tod_ff;
                    A_IRQ_ST: rdata_o <= {28'h0000000, irq_st_ff};
                    A_IRQ_MSK: rdata_o <= {28'h0000000, irq_msk_ff};
                    default: rdata_o <= '0;
                endcase
            end
        end
    end

    property p_b5_zero;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (ce_i && tx_frame_i && tx_idx_ff >= B5_FIRST && tx_idx_ff <= B5_LAST) |=> !tx_bit_o;
    endproperty
    a_b5_zero: assert property (p_b5_zero) else $error("byte 5 bit sent as one");

    property p_b22_rsv;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (ce_i && tx_frame_i && tx_idx_ff >= B22_FIRST && tx_idx_ff <= B22_RSV_LST) |=> !tx_bit_o;
    endproperty
    a_b22_rsv: assert property (p_b22_rsv) else $error("byte 22 reserved bit sent as one");

    property p_ref_ok;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (ce_i && tx_frame_i && tx_idx_ff == 8'h00) |=> (tx_blk_ff[33:32] != REF_RSV);
    endproperty
    a_ref_ok: assert property (p_ref_ok) else $error("reserved reference pattern queued");

    property p_bos;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (ce_i && tx_frame_i) |=> (tx_bos_o == ($past(tx_idx_ff) == 8'h00));
    endproperty
    a_bos: assert property (p_bos) else $error("block start marker misplaced");

    property p_chan;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        rx_b3_ff[7] ? (rx_chan_o == {4'h0, rx_b3_ff[3:0]} + 8'h01)
                    : (rx_chan_o == {1'b0, rx_b3_ff[6:0]} + 8'h01);
    endproperty
    a_chan: assert property (p_chan) else $error("channel number decode wrong");

    property p_crc_unrel;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (rx_done && nxt_rx_crc != 8'h00) |=> (rx_rel_o == 4'h0 && !rx_crc_ok_o && irq_st_ff[IRQ_CRC_ERR]);
    endproperty
    a_crc_unrel: assert property (p_crc_unrel) else $error("bad check byte not flagged");

    property p_lsa;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        rx_done |=> (rx_lsa_ff == $past(rx_blk[143:112]) && rx_tod_ff == $past(rx_blk[175:144]));
    endproperty
    a_lsa: assert property (p_lsa) else $error("sample address not captured");

    property p_mode;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        rx_mode_rsvd_o |-> (rx_mc_o && rx_mode_o != MODE_USER && rx_mode_o != MODE_0);
    endproperty
    a_mode: assert property (p_mode) else $error("multichannel mode class wrong");
endmodule

/* csu_link_model.sv */
// Far-side link model: pulls transmit bits and loops them back as received bits.
`timescale 1ns/1ns
module csu_link_model (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         run_i,
    input  wire logic [2:0]   gap_i,
    input  wire logic [7:0]   flip_i,
    input  wire logic         tx_bit_i,
    input  wire logic         tx_bos_i,
    output logic              tx_frame_o,
    output logic              rx_frame_o,
    output logic              rx_bit_o,
    output logic              rx_bos_o,
    output logic [191:0]      blk_o,
    output logic [7:0]        nblk_o
);
    logic [3:0] ph_ff;
    logic [7:0] idx_ff;
    logic [7:0] cur;
    assign cur = tx_bos_i ? 8'h00 : idx_ff + 8'h01;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ph_ff <= 4'h0;
            idx_ff <= 8'hbf;
            tx_frame_o <= 1'b0;
            rx_frame_o <= 1'b0;
            rx_bit_o <= 1'b0;
            rx_bos_o <= 1'b0;
            blk_o <= '0;
            nblk_o <= 8'h00;
        end else begin
            tx_frame_o <= 1'b0;
            rx_frame_o <= 1'b0;
            rx_bos_o <= 1'b0;
            if (ph_ff == 4'h0) begin
                if (run_i) begin
                    tx_frame_o <= 1'b1;
                    ph_ff <= 4'h1;
                end
            end else if (ph_ff == 4'h2) begin
                // A flipped bit stands for line damage; only the bench asks for it.
                rx_bit_o <= tx_bit_i ^ (cur == flip_i);
                rx_frame_o <= 1'b1;
                rx_bos_o <= tx_bos_i;
                blk_o[cur] <= tx_bit_i;
                idx_ff <= cur;
                if (cur == 8'hbf) begin
                    nblk_o <= nblk_o + 8'h01;
                end
                ph_ff <= 4'h3;
            end else begin
                // Between frames the data line shows the inverse, never a stale copy.
                if (ph_ff == 4'h3) begin
                    rx_bit_o <= ~rx_bit_o;
                end
                ph_ff <= (ph_ff >= 4'h3 + {1'b0, gap_i}) ? 4'h0 : ph_ff + 4'h1;
            end
        end
    end
endmodule

/* csu_pkg.sv */
// Constants shared by the channel status upper-byte codec.
package csu_pkg;
    localparam int          BLK_BITS   = 192;
    localparam int          CRC_BIT0   = 184;
    localparam logic [7:0]  BLK_LAST   = 8'hbf;
    localparam logic [7:0]  CRC_FIRST  = 8'hb8;
    localparam logic [7:0]  B5_FIRST   = 8'h28;
    localparam logic [7:0]  B5_LAST    = 8'h2f;
    localparam logic [7:0]  B22_FIRST  = 8'hb0;
    localparam logic [7:0]  B22_RSV_LST = 8'hb3;
    localparam logic [7:0]  CRC_INIT   = 8'hff;
    localparam logic [7:0]  CRC_POLY_R = 8'hb8;
    localparam logic [7:0]  A_TX_HDR   = 8'h00;
    localparam logic [7:0]  A_TX_FMT   = 8'h04;
    localparam logic [7:0]  A_TX_ORG   = 8'h08;
    localparam logic [7:0]  A_TX_DST   = 8'h0c;
    localparam logic [7:0]  A_TX_LSA   = 8'h10;
    localparam logic [7:0]  A_TX_TOD   = 8'h14;
    localparam logic [7:0]  A_RX_HDR   = 8'h18;
    localparam logic [7:0]  A_RX_FMT   = 8'h1c;
    localparam logic [7:0]  A_RX_ORG   = 8'h20;
    localparam logic [7:0]  A_RX_DST   = 8'h24;
    localparam logic [7:0]  A_RX_LSA   = 8'h28;
    localparam logic [7:0]  A_RX_TOD   = 8'h2c;
    localparam logic [7:0]  A_IRQ_ST   = 8'h30;
    localparam logic [7:0]  A_IRQ_MSK  = 8'h34;
    localparam logic [23:0] TX_HDR_RST = 24'h000001;
    localparam logic [19:0] TX_FMT_RST = 20'h00000;
    localparam logic [3:0]  IRQ_MSK_RST = 4'h0;
    localparam int          IRQ_RX_DONE = 0;
    localparam int          IRQ_CRC_ERR = 1;
    localparam int          IRQ_TX_BLK  = 2;
    localparam int          IRQ_RX_RSV  = 3;
    localparam logic [2:0]  MODE_0     = 3'b000;
    localparam logic [2:0]  MODE_2     = 3'b010;
    localparam logic [2:0]  MODE_3     = 3'b011;
    localparam logic [2:0]  MODE_4     = 3'b001;
    localparam logic [2:0]  MODE_USER  = 3'b111;
    localparam logic [1:0]  REF_RSV    = 2'b11;
endpackage
